// [design/srop_consts.svh]
// Constants for the serial ready output port: field positions and counts.
// Assumes inclusion by name from the package and the design file.
`ifndef SROP_CONSTS_SVH
`define SROP_CONSTS_SVH
`define SROP_CMD_BITS      8
`define SROP_CMD_WEN       7
`define SROP_CMD_RNW       6
`define SROP_CMD_RS_HI     5
`define SROP_CMD_RS_LO     3
`define SROP_CMD_CONT      2
`define SROP_RESET_ONES    32
`define SROP_DATA_REG_SEL  3'h3
`define SROP_STAT_REG_SEL  3'h0
`define SROP_FIFO_DEPTH    8
`endif

// [design/srop_pkg.sv]
// Types for the serial ready output port.
// Assumes srop_consts.svh is on the include path.
`include "srop_consts.svh"
package srop_pkg;
   typedef enum logic [1:0] {
      SROP_CMD  = 2'b00,
      SROP_RD   = 2'b01,
      SROP_WR   = 2'b10
   } srop_state_t;
   typedef struct packed {
      logic [2:0]  sel;
      logic [23:0] data;
   } srop_wr_t;
endpackage

// [design/srop_port.sv]
// Serial port with combined data-out / ready pin, FIFO of register writes.
// Assumes serial pins are asynchronous; register file lives outside.
//
// Overview of operation
// - Ready pin goes low when a conversion finishes.
// - An unread result lets the pin return high before the next update.
// - Output bits change on the serial clock falling edge, host samples on rising.
// - The pin is released whenever chip select is high.
// - A ready status bit tracks completion regardless of chip select.
// - The output shift register loads from whichever register is read.
// - Input bits shift in and go to the register chosen by the select field.
// - A transaction starts with a command byte and returns to that wait; a continuous read stays in the read state.
// - Thirty-two consecutive ones on data-in reset the command state and continuous read; queued writes are kept.
// - Command byte is MSB first with write-enable, direction, select, continuous bits.
// - A leading one holds the command at its first bit until a zero arrives.
`timescale 1ns/1ns
`include "srop_consts.svh"
module srop_fifo #(
   parameter int WIDTH = 27,
   parameter int DEPTH = `SROP_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             sys_rst,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic             push, pop;
   // Full when pointers differ only in the wrap bit
   assign inReady  = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
   assign outValid = wrPtr_q != rdPtr_q;
   assign outData  = mem[rdPtr_q[AW-1:0]];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   // Pointer next values
   always_comb begin
      wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
      rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
   end
   // Pointer and storage registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
      end
      if (push) begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
module srop_port
   import srop_pkg::*;
#(
   parameter int DATA_BITS = 24
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // Serial pins
   input  wire logic        csN,
   input  wire logic        sclk,
   input  wire logic        din,
   output logic             doutRdyOut,
   output logic             doutRdyOe,
   // Converter side
   input  wire logic        convDone,
   input  wire logic        updateSoon,
   input  wire logic [23:0] convData,
   // Read source: register value for the selected address
   output logic [2:0]       readSel,
   input  wire logic [23:0] readData,
   input  wire logic [4:0]  readLen,
   // Register write stream
   output logic             wrValid,
   input  wire logic        wrReady,
   output logic [2:0]       wrSel,
   output logic [23:0]      wrData,
   input  wire logic [4:0]  wrLen,
   // Status
   output logic             rdyStatus,
   output logic             continuousReadout,
   output logic             portReset
);
   srop_state_t state_q, state_d;
   logic [2:0]  csS_q, sclkS_q, dinS_q;
   logic        sclkRise, sclkFall, csHigh, dinB;
   logic [6:0]  cmd_q, cmd_d;
   logic [2:0]  cmdCnt_q, cmdCnt_d;
   logic        cmdGo_q, cmdGo_d;
   logic [2:0]  register_select_field_q, register_select_field_d;
   logic        contRd_q, contRd_d;
   logic [23:0] shOut_q, shOut_d, shIn_q, shIn_d;
   logic [4:0]  bitCnt_q, bitCnt_d;
   logic [5:0]  ones_q, ones_d;
   logic        rdy_q, rdy_d, out_q, out_d, oe_q, oe_d;
   logic        push, fifoReady, rst_q, rst_d, resetHit;
   srop_wr_t    fifoIn, fifoOut;
   logic        fifoValid, fifoPop;
   logic [7:0]  cmdByte;
   logic [23:0] outWord;

   // Three-stage synchronisers; only stage two onward feeds logic
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         csS_q   <= 3'h7;
         sclkS_q <= 3'h7;
         dinS_q  <= 3'h0;
      end else begin
         csS_q   <= {csS_q[1:0], csN};
         sclkS_q <= {sclkS_q[1:0], sclk};
         dinS_q  <= {dinS_q[1:0], din};
      end
   end
   assign sclkRise = sclkS_q[1] && !sclkS_q[2];
   assign sclkFall = !sclkS_q[1] && sclkS_q[2];
   assign csHigh   = csS_q[1];
   assign dinB     = dinS_q[1];
   assign resetHit = sclkRise && !csHigh && dinB
                     && ones_q == 6'(`SROP_RESET_ONES - 1);
   // Command byte on its last bit, and the word that the next fall shifts
   assign cmdByte  = {1'b0, cmd_q[5:0], dinB};
   assign outWord  = bitCnt_q != 5'h0 ? shOut_q :
                     register_select_field_q == `SROP_DATA_REG_SEL ?
                     convData : readData;

   // Serial engine next values
   always_comb begin
      state_d  = state_q;
      cmd_d    = cmd_q;
      cmdCnt_d = cmdCnt_q;
      cmdGo_d  = cmdGo_q;
      register_select_field_d = register_select_field_q;
      contRd_d = contRd_q;
      shOut_d  = shOut_q;
      shIn_d   = shIn_q;
      bitCnt_d = bitCnt_q;
      ones_d   = ones_q;
      rdy_d    = rdy_q;
      out_d    = out_q;
      push     = 1'b0;
      rst_d    = 1'b0;
      // Completion drops ready; a pending update with no read raises it
      if (convDone) begin
         rdy_d = 1'b0;
      end else if (updateSoon && rdy_q == 1'b0) begin
         rdy_d = 1'b1;
      end
      if (sclkRise && !csHigh) begin
         ones_d = dinB ? ones_q + 6'h01 : 6'h00;
      end
      case (state_q)
         SROP_CMD: begin
            if (sclkRise && !csHigh) begin
               if (!cmdGo_q) begin
                  cmdGo_d = !dinB;
               end else begin
                  cmd_d    = {cmd_q[5:0], dinB};
                  cmdCnt_d = cmdCnt_q + 3'h1;
                  if (cmdCnt_q == 3'h6) begin
                     cmdGo_d  = 1'b0;
                     cmdCnt_d = 3'h0;
                     register_select_field_d =
                        cmdByte[`SROP_CMD_RS_HI:`SROP_CMD_RS_LO];
                     contRd_d = cmdByte[`SROP_CMD_CONT] &&
                        register_select_field_d == `SROP_DATA_REG_SEL;
                     bitCnt_d = 5'h0;
                     shIn_d   = 24'h000000;
                     state_d  = cmdByte[`SROP_CMD_RNW] ? SROP_RD : SROP_WR;
                  end
               end
            end
         end
         SROP_RD: begin
            // Source is taken on the first fall, when readSel has settled;
            // the last bit stands until the host's sampling rise
            if (sclkFall && !csHigh && bitCnt_q != readLen) begin
               out_d    = outWord[readLen - 5'h1];
               shOut_d  = {outWord[22:0], 1'b0};
               bitCnt_d = bitCnt_q + 5'h1;
            end
            if (sclkRise && !csHigh && bitCnt_q == readLen) begin
               state_d  = contRd_q ? SROP_RD : SROP_CMD;
               bitCnt_d = 5'h0;
            end
            if (contRd_q && sclkRise && !csHigh) begin
               cmd_d = {cmd_q[5:0], dinB};
            end
         end
         SROP_WR: begin
            // A word that meets a full FIFO is dropped; the frame still ends
            if (sclkRise && !csHigh) begin
               shIn_d   = {shIn_q[22:0], dinB};
               bitCnt_d = bitCnt_q + 5'h1;
               if (bitCnt_q == wrLen - 5'h1) begin
                  push    = fifoReady;
                  state_d = SROP_CMD;
               end
            end
         end
         default: state_d = SROP_CMD;
      endcase
      if (resetHit) begin
         state_d  = SROP_CMD;
         cmdGo_d  = 1'b0;
         cmdCnt_d = 3'h0;
         contRd_d = 1'b0;
         ones_d   = 6'h00;
         rst_d    = 1'b1;
      end
   end
   assign fifoIn = '{sel: register_select_field_q, data: shIn_d};

   // Pin drive: ready level when idle, data bit when reading
   always_comb begin
      oe_d = !csHigh;
   end

   // Serial engine registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q  <= SROP_CMD;
         cmd_q    <= 7'h00;
         cmdCnt_q <= 3'h0;
         cmdGo_q  <= 1'b0;
         register_select_field_q <= 3'h0;
         contRd_q <= 1'b0;
         shOut_q  <= 24'h000000;
         shIn_q   <= 24'h000000;
         bitCnt_q <= 5'h00;
         ones_q   <= 6'h00;
         rdy_q    <= 1'b1;
         out_q    <= 1'b1;
         oe_q     <= 1'b0;
         rst_q    <= 1'b0;
      end else begin
         state_q  <= state_d;
         cmd_q    <= cmd_d;
         cmdCnt_q <= cmdCnt_d;
         cmdGo_q  <= cmdGo_d;
         register_select_field_q <= register_select_field_d;
         contRd_q <= contRd_d;
         shOut_q  <= shOut_d;
         shIn_q   <= shIn_d;
         bitCnt_q <= bitCnt_d;
         ones_q   <= ones_d;
         rdy_q    <= rdy_d;
         out_q    <= (state_d == SROP_RD) ? out_d : rdy_d;
         oe_q     <= oe_d;
         rst_q    <= rst_d;
      end
   end

   srop_fifo #(.WIDTH(27), .DEPTH(`SROP_FIFO_DEPTH)) wrFifo (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .inValid  (push),
      .inReady  (fifoReady),
      .inData   (fifoIn),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoOut)
   );

   // Output stage refills when empty or taken, so no word is skipped
   assign fifoPop = fifoValid && (!wrValid || wrReady);
   // Registered outputs
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wrValid <= 1'b0;
         wrSel   <= 3'h0;
         wrData  <= 24'h000000;
         readSel <= 3'h0;
      end else begin
         readSel <= register_select_field_d;
         if (fifoPop) begin
            wrValid <= 1'b1;
            wrSel   <= fifoOut.sel;
            wrData  <= fifoOut.data;
         end else if (wrReady) begin
            wrValid <= 1'b0;
         end
      end
   end
   assign doutRdyOut        = out_q;
   assign doutRdyOe         = oe_q;
   assign rdyStatus         = rdy_q;
   assign continuousReadout = contRd_q;
   assign portReset         = rst_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence convEnd_s;
      convDone;
   endsequence
   readyLow_a: assert property (@(posedge clock) disable iff (sys_rst)
      convEnd_s |=> !rdyStatus) else $error("ready not low");
   readyHigh_a: assert property (@(posedge clock) disable iff (sys_rst)
      !convDone && updateSoon && !rdyStatus |=> rdyStatus)
      else $error("ready not raised");
   releaseCs_a: assert property (@(posedge clock) disable iff (sys_rst)
      csS_q[1] |=> !doutRdyOe) else $error("pin driven with cs high");
   idleReady_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_q == SROP_CMD && state_d == SROP_CMD |=> doutRdyOut == rdyStatus)
      else $error("idle pin not ready");
   onesReset_a: assert property (@(posedge clock) disable iff (sys_rst)
      resetHit |=> portReset && state_q == SROP_CMD)
      else $error("no reset after ones");
   holdFirst_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_q == SROP_CMD && !cmdGo_q && sclkRise && !csHigh && dinB
      |=> !cmdGo_q) else $error("advanced on leading one");
   fallOnly_a: assert property (@(posedge clock) disable iff (sys_rst)
      state_q == SROP_RD && state_d == SROP_RD && !sclkFall
      |=> $stable(doutRdyOut)) else $error("bit moved off falling edge");
   writePush_a: assert property (@(posedge clock) disable iff (sys_rst)
      push |=> state_q == SROP_CMD) else $error("write did not end");
endmodule

// [bench/srop_host_model.sv]
// Host model: drives chip select, serial clock and data in.
// Assumes the bench calls sel and shift; clock is the bench clock.
`timescale 1ns/1ns
module srop_host_model (
   // System clock
   input  wire logic clock,
   // Serial pins
   output logic      csN,
   output logic      sclk,
   output logic      din,
   input  wire logic doutRdy
);
   // Serial clock idles high and stands still between frames
   initial begin
      csN  = 1'b1;
      sclk = 1'b1;
      din  = 1'b0;
   end
   // Chip select level, changed on a clock edge
   task automatic sel(input logic v);
      @(posedge clock) csN <= v;
      repeat (3) @(posedge clock);
   endtask
   // Shift n bits MSB first; low 5 clocks so the bit has settled
   task automatic shift(input logic [31:0] tx, input int n,
                        output logic [31:0] rx);
      rx = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clock) sclk <= 1'b0;
         din <= tx[i];
         repeat (5) @(posedge clock);
         sclk <= 1'b1;
         rx = {rx[30:0], doutRdy};
         repeat (2) @(posedge clock);
      end
   endtask
endmodule

// [bench/srop_port_bench.sv]
// Bench: host model on the serial pins, bench on the converter side.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ns
module srop_port_bench
   import srop_pkg::*;
();
   // Clock, reset and converter side
   logic        clock = 1'b0;
   logic        sysRst;
   logic        convDone;
   logic        updateSoon;
   logic [23:0] convData;
   logic [4:0]  readLen;
   logic [4:0]  wrLen;
   logic        wrReady;
   logic [23:0] regFile [8];
   wire  [23:0] readData;
   // Serial pins and design outputs
   wire         csN, sclk, din, pinLevel;
   logic        doutRdyOut, doutRdyOe, wrValid, rdyStatus;
   logic        continuousReadout, portReset;
   logic [2:0]  readSel, wrSel;
   logic [23:0] wrData;
   // Bookkeeping
   int          n_fail = 0;
   int          total_checks = 0;
   int          nRst = 0;
   srop_wr_t    expQ [$];
   logic [31:0] rx;

   always #20 clock = ~clock;
   // Register file outside the port answers in the same clock
   assign readData = regFile[readSel];
   // No pull on the line: a released pin shows the inverse level
   assign pinLevel = doutRdyOe ? doutRdyOut : !doutRdyOut;

   srop_port u_dut (.clock(clock), .sys_rst(sysRst), .csN(csN),
      .sclk(sclk), .din(din), .doutRdyOut(doutRdyOut),
      .doutRdyOe(doutRdyOe), .convDone(convDone),
      .updateSoon(updateSoon), .convData(convData), .readSel(readSel),
      .readData(readData), .readLen(readLen), .wrValid(wrValid),
      .wrReady(wrReady), .wrSel(wrSel), .wrData(wrData), .wrLen(wrLen),
      .rdyStatus(rdyStatus), .continuousReadout(continuousReadout),
      .portReset(portReset));
   srop_host_model u_host (.clock(clock), .csN(csN), .sclk(sclk),
      .din(din), .doutRdy(pinLevel));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic conv();
      @(posedge clock);
      convDone <= 1'b1;
      convData <= 24'($urandom);
      @(posedge clock) convDone <= 1'b0;
      cyc(4);
   endtask
   // Leading ones ahead of the command must be skipped
   task automatic cmd(input logic [7:0] c, input int lead);
      u_host.shift({24'hFFFFFF, c}, 8 + lead, rx);
   endtask
   task automatic rd(input logic [2:0] s, input logic [23:0] e, int lead);
      u_host.sel(1'b0);
      cmd({2'b01, s, 3'b000}, lead);
      cyc(4);
      check("readSel", s, readSel);
      u_host.shift(32'h0, readLen, rx);
      u_host.sel(1'b1);
      check("read", e & ((24'h1 << readLen) - 24'h1), rx);
   endtask
   // Note goes in the queue before the word can appear
   task automatic wr(input logic [2:0] s, input int len, input logic keep);
      logic [23:0] d;
      d = 24'($urandom) & ((24'h1 << len) - 24'h1);
      @(posedge clock) wrLen <= 5'(len);
      if (keep) expQ.push_back({s, d});
      u_host.sel(1'b0);
      cmd({2'b00, s, 3'b000}, 0);
      u_host.shift({8'h0, d}, len, rx);
      u_host.sel(1'b1);
   endtask

   // Each accepted write is matched against the oldest note
   always @(posedge clock) begin
      srop_wr_t e;
      if (!sysRst && wrValid === 1'b1 && wrReady === 1'b1) begin
         e = (expQ.size() > 0) ? expQ.pop_front() : '1;
         check("write", e, {wrSel, wrData});
      end
      if (portReset === 1'b1) nRst++;
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      sysRst     = 1'b1;
      convDone   = 1'b0;
      updateSoon = 1'b0;
      readLen    = 5'h18;
      wrLen      = 5'h18;
      wrReady    = 1'b1;
      rx = 32'($urandom(32'h6451));
      foreach (regFile[i]) regFile[i] = 24'($urandom);
      convData <= 24'($urandom);
      cyc(5);
      sysRst <= 1'b0;
      cyc(4);
      check("oe", 1'h0, doutRdyOe);
      check("pin", 1'h1, doutRdyOut);
      check("rdyStatus", 1'h1, rdyStatus);
      $display("test reset done");
      conv();
      check("rdyStatus", 1'h0, rdyStatus);
      check("oe", 1'h0, doutRdyOe);
      u_host.sel(1'b0);
      cyc(4);
      check("oe", 1'h1, doutRdyOe);
      check("pin", 1'h0, pinLevel);
      @(posedge clock) updateSoon <= 1'b1;
      @(posedge clock) updateSoon <= 1'b0;
      cyc(4);
      check("pin", 1'h1, pinLevel);
      u_host.sel(1'b1);
      $display("test ready done");
      rd(3'h3, convData, 2);
      for (int s = 1; s < 8; s++) begin
         if (s == 3) continue;
         @(posedge clock) readLen <= 5'(1 + $urandom % 24);
         rd(3'(s), regFile[s], 0);
      end
      $display("test read done");
      // Stall the far side: eight queued plus one on the outputs fit,
      // the tenth is lost
      @(posedge clock) wrReady <= 1'b0;
      for (int i = 0; i < 10; i++) wr(3'(1 + $urandom % 7),
         1 + $urandom % 24, i < 9);
      check("stalled", 1'h1, wrValid);
      @(posedge clock) wrReady <= 1'b1;
      cyc(30);
      check("drained", 32'h0, expQ.size());
      $display("test buffer done");
      u_host.sel(1'b0);
      u_host.shift(32'hFFFFFFFF, 32, rx);
      u_host.sel(1'b1);
      cyc(4);
      check("portReset", 32'h1, nRst);
      wr(3'h2, 24, 1'b1);
      conv();
      @(posedge clock) readLen <= 5'h18;
      u_host.sel(1'b0);
      cmd(8'h5C, 0);
      cyc(4);
      check("continuous", 1'h1, continuousReadout);
      u_host.shift(32'hFFFFFFFF, 32, rx);
      check("stream", {convData, convData[23:16]}, rx);
      u_host.sel(1'b1);
      cyc(4);
      check("portReset", 32'h2, nRst);
      check("continuous", 1'h0, continuousReadout);
      check("queue", 32'h0, expQ.size());
      $display("test reset sequence done");
      final_report();
   end

   // Watchdog well beyond the expected run length
   initial begin
      #800000;
      n_fail++;
      final_report();
   end
endmodule
